/* tb/umd_bus_model.sv */
`timescale 1ns/1ps
module umd_bus_model (
	input  wire logic         mclk_i,
	output umd_pkg::umd_req_t cpu_req_o,
	output umd_pkg::umd_req_t dma_req_o
);
	initial
	begin
		cpu_req_o = '0;
		dma_req_o = '0;
	end
	// One-cycle request from either or both masters
	task automatic issue(input logic c, input logic d, input logic we,
		input logic f, input logic [15:0] ca, input logic [15:0] da);
		@(posedge mclk_i);
		cpu_req_o <= '{c, we, f, ca};
		dma_req_o <= '{d, we, 1'b0, da};
		@(posedge mclk_i);
		// Released bus shows inverted we and address, fetch low, never a stale request
		cpu_req_o <= '{1'b0, ~we, 1'b0, ~ca};
		dma_req_o <= '{1'b0, ~we, 1'b0, ~da};
	endtask
endmodule // umd_bus_model

/* tb/unified_memory_map_decoder_tb.sv */
`timescale 1ns/1ps
module unified_memory_map_decoder_tb;
	logic                mclk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic                cache_disable_i = 1'b0;
	umd_pkg::umd_pmode_t pmode_i = umd_pkg::UMD_PM_ACTIVE;
	logic [7:0]          sreg_addr_i = 8'h00;
	logic                sreg_internal_i = 1'b0;
	logic [7:0]          idata_addr_i = 8'h00;
	logic                idata_indirect_i = 1'b0;
	umd_pkg::umd_req_t   cpu_req, dma_req;
	logic                s_fl, s_sr, s_id, s_ra, s_au, s_sg, s_us, unm;
	logic                we_o, cf_o, ff_o, grant, wipe, sb, ib, iok, ibk;
	logic [15:0]         addr_o;
	int                  error_cnt = 0;
	int                  tests_run = 0;
	int                  cyc = 0;
	wire logic [7:0] sel = {s_us, s_sg, s_au, s_ra, s_id, s_sr, s_fl, unm};

	initial
	begin
		forever #2 mclk_i = ~mclk_i;
	end

	umd_bus_model m (.mclk_i(mclk_i), .cpu_req_o(cpu_req),
		.dma_req_o(dma_req));

	umd_decoder umd_decoder_inst (.mclk_i(mclk_i), .rst_i(rst_i),
		.cpu_req_i(cpu_req), .dma_req_i(dma_req),
		.cache_disable_i(cache_disable_i), .pmode_i(pmode_i),
		.sreg_addr_i(sreg_addr_i), .sreg_internal_i(sreg_internal_i),
		.idata_addr_i(idata_addr_i), .idata_indirect_i(idata_indirect_i),
		.sel_flash_o(s_fl), .sel_sram_o(s_sr), .sel_idata_o(s_id),
		.sel_radio_o(s_ra), .sel_audio_o(s_au), .sel_sreg_o(s_sg),
		.sel_usb_o(s_us), .we_o(we_o), .cache_fetch_o(cf_o),
		.flash_fetch_o(ff_o), .dma_grant_o(grant), .unmapped_o(unm),
		.addr_o(addr_o), .wipe_volatile_o(wipe), .sreg_bit_ok_o(sb),
		.idata_bit_ok_o(ib), .idata_ok_o(iok), .idata_bank_o(ibk));

	task automatic chk_b(input logic g, input logic e);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t flag %b exp %b", $time, g, e);
		end
	endtask

	task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t value %h exp %h", $time, g, e);
		end
	endtask

	// Target index: 0 unmapped, 1 flash, 2 sram, 3 idata, 4 radio, 5 audio,
	// 6 special registers, 7 usb; data and fetch must decode alike
	task automatic dec(input logic [15:0] a, input int t);
		for (int f = 0; f < 2; f++)
		begin
			m.issue(1'b1, 1'b0, 1'b0, f[0], a, 16'h0000);
			#1;
			chk_v({8'h00, sel}, {8'h00, 8'h01 << t});
			if (t != 0)
				chk_v(addr_o, a);
		end
	endtask

	task automatic t_map;
		dec(16'h0000, 1);
		dec(16'h7fff, 1);
		dec(16'h8000, 0);
		dec(16'hefff, 0);
		dec(16'hf000, 2);
		dec(16'hfeff, 2);
		dec(16'hff00, 3);
		dec(16'hffff, 3);
		dec(16'hdf00, 4);
		dec(16'hdf3d, 4);
		dec(16'hdf3e, 0);
		dec(16'hdf40, 5);
		dec(16'hdf48, 5);
		dec(16'hdf49, 0);
		dec(16'hdf80, 6);
		dec(16'hdfff, 6);
		dec(16'hde00, 7);
		dec(16'hde3f, 7);
		dec(16'hde40, 0);
		@(posedge mclk_i) sreg_internal_i <= 1'b1;
		dec(16'hdf80, 0);
		attr(8'h00, 1'b0, 8'he0, 4'b1101);
		@(posedge mclk_i) sreg_internal_i <= 1'b0;
	endtask

	task automatic t_bus;
		// A bus write never programs flash
		m.issue(1'b1, 1'b0, 1'b1, 1'b0, 16'h0010, 16'h0000);
		#1 chk_b(we_o, 1'b0);
		m.issue(1'b1, 1'b1, 1'b1, 1'b0, 16'hf010, 16'hff20);
		#1 chk_b(we_o, 1'b1);
		chk_b(grant, 1'b0);
		chk_v(addr_o, 16'hf010);
		m.issue(1'b0, 1'b1, 1'b1, 1'b0, 16'h0000, 16'hff20);
		#1 chk_b(grant, 1'b1);
		chk_v({8'h00, sel}, 16'h0008);
		for (int d = 0; d < 2; d++)
		begin
			@(posedge mclk_i) cache_disable_i <= d[0];
			m.issue(1'b1, 1'b0, 1'b0, 1'b1, 16'h0100, 16'h0000);
			#1 chk_b(cf_o, ~d[0]);
			chk_b(ff_o, d[0]);
		end
	endtask

	task automatic t_sleep;
		for (int p = 1; p < 4; p++)
		begin
			@(posedge mclk_i) pmode_i <= umd_pkg::umd_pmode_t'(p);
			@(posedge mclk_i) #1 chk_b(wipe, p >= 2);
			@(posedge mclk_i) #1 chk_b(wipe, 1'b0);
			m.issue(1'b1, 1'b0, 1'b0, 1'b0, 16'hf000, 16'h0000);
			#1 chk_b(s_sr, p < 2);
			@(posedge mclk_i) pmode_i <= umd_pkg::UMD_PM_ACTIVE;
			repeat (2) @(posedge mclk_i);
		end
	endtask

	// Expected flags: {idata ok, bank, bit addressable, sreg bit access}
	task automatic attr(input logic [7:0] ia, input logic ind,
		input logic [7:0] sa, input logic [3:0] e);
		@(posedge mclk_i);
		idata_addr_i <= ia;
		idata_indirect_i <= ind;
		sreg_addr_i <= sa;
		@(posedge mclk_i);
		#1 chk_v({iok, ibk, ib, sb},
			{12'h000, e});
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			test_done();
		end
	end

	initial
	begin
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1 chk_v({8'h00, sel}, 16'h0000);
		t_map();
		t_bus();
		t_sleep();
		attr(8'h2f, 1'b0, 8'h80, 4'b1111);
		attr(8'h30, 1'b0, 8'h81, 4'b1000);
		attr(8'h80, 1'b0, 8'h88, 4'b0001);
		attr(8'h80, 1'b1, 8'h8f, 4'b1000);
		attr(8'h1f, 1'b1, 8'hf8, 4'b1101);
		test_done();
	end
endmodule // unified_memory_map_decoder_tb

/* verilog/umd_cfg.svh */
`ifndef UMD_CFG_SVH
`define UMD_CFG_SVH
`define UMD_FLASH_END_8K    16'h1fff
`define UMD_FLASH_END_16K   16'h3fff
`define UMD_FLASH_END_32K   16'h7fff
`define UMD_SRAM_BASE       16'hf000
`define UMD_SRAM_HOLE_1K    16'hf300
`define UMD_SRAM_HOLE_2K    16'hf700
`define UMD_SRAM_HOLE_END   16'hfeff
`define UMD_VOLATILE_LO     16'hfda2
`define UMD_VOLATILE_HI     16'hfeff
`define UMD_IDATA_BASE      16'hff00
`define UMD_RADIO_LO        16'hdf00
`define UMD_RADIO_HI        16'hdf3d
`define UMD_AUDIO_LO        16'hdf40
`define UMD_AUDIO_HI        16'hdf48
`define UMD_SREG_LO         16'hdf80
`define UMD_SREG_HI         16'hdfff
`define UMD_USB_LO          16'hde00
`define UMD_USB_HI          16'hde3f
`define UMD_BANK_TOP        8'h2f
`define UMD_BIT_LO          8'h20
`define UMD_BIT_HI          8'h2f
`define UMD_UPPER_IDATA     8'h80
`define UMD_BITSEL_MASK     8'h07
`endif

/* verilog/umd_decoder.sv */
`timescale 1ns/1ps
`include "umd_cfg.svh"
module umd_decoder #(
	parameter int FLASH_KB = 32,
	parameter int SRAM_KB  = 4,
	parameter bit HAS_USB  = 1'b1
) (
	input  wire logic               mclk_i,
	input  wire logic               rst_i,
	input  wire umd_pkg::umd_req_t  cpu_req_i,
	input  wire umd_pkg::umd_req_t  dma_req_i,
	input  wire logic               cache_disable_i,
	input  wire umd_pkg::umd_pmode_t pmode_i,
	input  wire logic [7:0]         sreg_addr_i,
	input  wire logic               sreg_internal_i,
	input  wire logic [7:0]         idata_addr_i,
	input  wire logic               idata_indirect_i,
	output logic                    sel_flash_o,
	output logic                    sel_sram_o,
	output logic                    sel_idata_o,
	output logic                    sel_radio_o,
	output logic                    sel_audio_o,
	output logic                    sel_sreg_o,
	output logic                    sel_usb_o,
	output logic                    we_o,
	output logic                    cache_fetch_o,
	output logic                    flash_fetch_o,
	output logic                    dma_grant_o,
	output logic                    unmapped_o,
	output logic [15:0]             addr_o,
	output logic                    wipe_volatile_o,
	output logic                    sreg_bit_ok_o,
	output logic                    idata_bit_ok_o,
	output logic                    idata_ok_o,
	output logic                    idata_bank_o
);
	// ====================================================================
	// Decode of one request
	// ====================================================================
	localparam logic [15:0] FLASH_END = (FLASH_KB == 8) ? `UMD_FLASH_END_8K :
		(FLASH_KB == 16) ? `UMD_FLASH_END_16K : `UMD_FLASH_END_32K;
	localparam logic [15:0] SRAM_HOLE = (SRAM_KB == 1) ? `UMD_SRAM_HOLE_1K :
		(SRAM_KB == 2) ? `UMD_SRAM_HOLE_2K : `UMD_IDATA_BASE;

	typedef struct packed {
		umd_pkg::umd_regs_t  r;
		logic                sreg_bit;
		logic                idata_bit;
		logic                idata_ok;
		logic                idata_bank;
	} umd_all_t;

	umd_all_t          st_reg;
	umd_all_t          st_next;
	umd_pkg::umd_req_t win;
	umd_pkg::umd_state_t pstate;
	logic [15:0]       a;
	logic              dma_win;
	logic              deep;

	always_comb
	begin
		st_next = st_reg;
		// CPU has priority; DMA is granted only in free cycles
		dma_win = dma_req_i.req && !cpu_req_i.req;
		win     = dma_win ? dma_req_i : cpu_req_i;
		a       = win.addr;
		deep    = (pmode_i == umd_pkg::UMD_PM_TWO) ||
			(pmode_i == umd_pkg::UMD_PM_THREE);
		pstate  = deep ? umd_pkg::UMD_S_SLEEP : umd_pkg::UMD_S_RUN;
		st_next.r = '0;
		st_next.r.addr = a;
		st_next.r.dma_grant = dma_win;
		if (win.req && pstate == umd_pkg::UMD_S_RUN)
		begin
			// Same decode for fetch and data access
			if (a <= FLASH_END)
				st_next.r.sel_flash = 1'b1;
			else if (a >= `UMD_IDATA_BASE)
				st_next.r.sel_idata = 1'b1;
			else if (a >= `UMD_SRAM_BASE && a < SRAM_HOLE)
				st_next.r.sel_sram = 1'b1;
			else if (a >= `UMD_SRAM_BASE && SRAM_KB >= 4)
				st_next.r.sel_sram = 1'b1;
			else if (a >= `UMD_RADIO_LO && a <= `UMD_RADIO_HI)
				st_next.r.sel_radio = 1'b1;
			else if (a >= `UMD_AUDIO_LO && a <= `UMD_AUDIO_HI)
				st_next.r.sel_audio = 1'b1;
			else if (a >= `UMD_SREG_LO && a <= `UMD_SREG_HI)
			begin
				// CPU-internal registers stay out of the mirror
				if (sreg_internal_i)
					st_next.r.unmapped = 1'b1;
				else
					st_next.r.sel_sreg = 1'b1;
			end
			else if (HAS_USB && a >= `UMD_USB_LO && a <= `UMD_USB_HI)
				st_next.r.sel_usb = 1'b1;
			else
				st_next.r.unmapped = 1'b1;
			// Flash is never written through this path
			st_next.r.we = win.we && !(a <= FLASH_END);
			if (win.fetch && a <= FLASH_END)
			begin
				st_next.r.cache_fetch = !cache_disable_i;
				st_next.r.flash_fetch = cache_disable_i;
			end
		end
		st_next.r.sleep = deep;
		// Only the volatile window is wiped on entry; idata kept
		st_next.r.wipe_volatile = deep && !st_reg.r.sleep;
		st_next.sreg_bit = sreg_addr_i >= `UMD_UPPER_IDATA &&
			((sreg_addr_i & `UMD_BITSEL_MASK) == 8'h00);
		st_next.idata_bit = idata_addr_i >= `UMD_BIT_LO &&
			idata_addr_i <= `UMD_BIT_HI;
		st_next.idata_ok = idata_addr_i < `UMD_UPPER_IDATA ||
			idata_indirect_i;
		st_next.idata_bank = idata_addr_i <= `UMD_BANK_TOP;
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign sel_flash_o     = st_reg.r.sel_flash;
	assign sel_sram_o      = st_reg.r.sel_sram;
	assign sel_idata_o     = st_reg.r.sel_idata;
	assign sel_radio_o     = st_reg.r.sel_radio;
	assign sel_audio_o     = st_reg.r.sel_audio;
	assign sel_sreg_o      = st_reg.r.sel_sreg;
	assign sel_usb_o       = st_reg.r.sel_usb;
	assign we_o            = st_reg.r.we;
	assign cache_fetch_o   = st_reg.r.cache_fetch;
	assign flash_fetch_o   = st_reg.r.flash_fetch;
	assign dma_grant_o     = st_reg.r.dma_grant;
	assign unmapped_o      = st_reg.r.unmapped;
	assign addr_o          = st_reg.r.addr;
	assign wipe_volatile_o = st_reg.r.wipe_volatile;
	assign sreg_bit_ok_o   = st_reg.sreg_bit;
	assign idata_bit_ok_o  = st_reg.idata_bit;
	assign idata_ok_o      = st_reg.idata_ok;
	assign idata_bank_o    = st_reg.idata_bank;

	// ====================================================================
	// Checks
	// ====================================================================
	property p_flash_dec;
		@(posedge mclk_i) disable iff (rst_i)
		(cpu_req_i.req && pmode_i == umd_pkg::UMD_PM_ACTIVE &&
			cpu_req_i.addr <= FLASH_END) |=> sel_flash_o;
	endproperty
	a_flash_dec: assert property (p_flash_dec) else $error("flash miss");

	property p_sram_dec;
		@(posedge mclk_i) disable iff (rst_i)
		sel_sram_o |-> addr_o >= `UMD_SRAM_BASE && addr_o < `UMD_IDATA_BASE;
	endproperty
	a_sram_dec: assert property (p_sram_dec) else $error("sram range");

	property p_wipe;
		@(posedge mclk_i) disable iff (rst_i)
		$rose(pmode_i == umd_pkg::UMD_PM_THREE ||
			pmode_i == umd_pkg::UMD_PM_TWO) |=> wipe_volatile_o;
	endproperty
	a_wipe: assert property (p_wipe) else $error("no wipe");

	property p_idata;
		@(posedge mclk_i) disable iff (rst_i)
		sel_idata_o |-> addr_o >= `UMD_IDATA_BASE;
	endproperty
	a_idata: assert property (p_idata) else $error("idata alias");

	property p_radio;
		@(posedge mclk_i) disable iff (rst_i)
		sel_radio_o |-> addr_o >= `UMD_RADIO_LO && addr_o <= `UMD_RADIO_HI;
	endproperty
	a_radio: assert property (p_radio) else $error("radio range");

	property p_audio;
		@(posedge mclk_i) disable iff (rst_i)
		sel_audio_o |-> addr_o >= `UMD_AUDIO_LO && addr_o <= `UMD_AUDIO_HI;
	endproperty
	a_audio: assert property (p_audio) else $error("audio range");

	property p_nowrite_flash;
		@(posedge mclk_i) disable iff (rst_i)
		sel_flash_o |-> !we_o;
	endproperty
	a_nowrite_flash: assert property (p_nowrite_flash)
		else $error("flash written");

	property p_onehot;
		@(posedge mclk_i) disable iff (rst_i)
		$onehot0({sel_flash_o, sel_sram_o, sel_idata_o, sel_radio_o,
			sel_audio_o, sel_sreg_o, sel_usb_o, unmapped_o});
	endproperty
	a_onehot: assert property (p_onehot) else $error("multi select");

	property p_cache;
		@(posedge mclk_i) disable iff (rst_i)
		cache_fetch_o |-> !$past(cache_disable_i) && sel_flash_o;
	endproperty
	a_cache: assert property (p_cache) else $error("cache bypass");

	property p_sreg_hidden;
		@(posedge mclk_i) disable iff (rst_i)
		sel_sreg_o |-> !$past(sreg_internal_i);
	endproperty
	a_sreg_hidden: assert property (p_sreg_hidden)
		else $error("internal register reached");

	property p_sreg_mirror;
		@(posedge mclk_i) disable iff (rst_i)
		(cpu_req_i.req && pmode_i == umd_pkg::UMD_PM_ACTIVE &&
			!sreg_internal_i && cpu_req_i.addr >= `UMD_SREG_LO &&
			cpu_req_i.addr <= `UMD_SREG_HI) |=> sel_sreg_o;
	endproperty
	a_sreg_mirror: assert property (p_sreg_mirror)
		else $error("mirror miss");

	property p_usb;
		@(posedge mclk_i) disable iff (rst_i)
		sel_usb_o |-> HAS_USB && addr_o >= `UMD_USB_LO &&
			addr_o <= `UMD_USB_HI;
	endproperty
	a_usb: assert property (p_usb)
		else $error("usb select");

	property p_unmapped;
		@(posedge mclk_i) disable iff (rst_i)
		unmapped_o |-> addr_o > FLASH_END && addr_o < `UMD_IDATA_BASE;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped range");

	property p_fetch_sram;
		@(posedge mclk_i) disable iff (rst_i)
		(cpu_req_i.req && cpu_req_i.fetch &&
			pmode_i == umd_pkg::UMD_PM_ACTIVE &&
			cpu_req_i.addr >= `UMD_SRAM_BASE &&
			cpu_req_i.addr < SRAM_HOLE) |=> sel_sram_o;
	endproperty
	a_fetch_sram: assert property (p_fetch_sram)
		else $error("fetch from sram");

	property p_dma_grant;
		@(posedge mclk_i) disable iff (rst_i)
		(dma_req_i.req && !cpu_req_i.req) |=>
			dma_grant_o && addr_o == $past(dma_req_i.addr);
	endproperty
	a_dma_grant: assert property (p_dma_grant)
		else $error("dma not granted");

	property p_cpu_first;
		@(posedge mclk_i) disable iff (rst_i)
		cpu_req_i.req |=>
			!dma_grant_o && addr_o == $past(cpu_req_i.addr);
	endproperty
	a_cpu_first: assert property (p_cpu_first)
		else $error("masters overlap");

	property p_indirect;
		@(posedge mclk_i) disable iff (rst_i)
		idata_ok_o |-> $past(idata_addr_i) < `UMD_UPPER_IDATA ||
			$past(idata_indirect_i);
	endproperty
	a_indirect: assert property (p_indirect)
		else $error("upper idata direct");

	property p_bank;
		@(posedge mclk_i) disable iff (rst_i)
		idata_bank_o |-> $past(idata_addr_i) <= `UMD_BANK_TOP;
	endproperty
	a_bank: assert property (p_bank)
		else $error("bank range");

	property p_bit;
		@(posedge mclk_i) disable iff (rst_i)
		idata_bit_ok_o |-> $past(idata_addr_i) >= `UMD_BIT_LO &&
			$past(idata_addr_i) <= `UMD_BIT_HI;
	endproperty
	a_bit: assert property (p_bit)
		else $error("bit area range");

	property p_sreg_bit;
		@(posedge mclk_i) disable iff (rst_i)
		sreg_bit_ok_o |-> $past(sreg_addr_i) >= `UMD_UPPER_IDATA &&
			($past(sreg_addr_i) & `UMD_BITSEL_MASK) == '0;
	endproperty
	a_sreg_bit: assert property (p_sreg_bit)
		else $error("register bit access");

	property p_flash_fetch;
		@(posedge mclk_i) disable iff (rst_i)
		flash_fetch_o |-> $past(cache_disable_i) && sel_flash_o;
	endproperty
	a_flash_fetch: assert property (p_flash_fetch)
		else $error("cache not bypassed");
endmodule // umd_decoder

/* verilog/umd_pkg.sv */
package umd_pkg;
	typedef enum logic [2:0] {
		UMD_T_NONE,
		UMD_T_FLASH,
		UMD_T_SRAM,
		UMD_T_IDATA,
		UMD_T_RADIO,
		UMD_T_AUDIO,
		UMD_T_SREG,
		UMD_T_USB
	} umd_target_t;

	typedef struct packed {
		logic        req;
		logic        we;
		logic        fetch;
		logic [15:0] addr;
	} umd_req_t;

	typedef enum logic [1:0] {
		UMD_PM_ACTIVE,
		UMD_PM_ONE,
		UMD_PM_TWO,
		UMD_PM_THREE
	} umd_pmode_t;

	typedef enum {
		UMD_S_RUN,
		UMD_S_SLEEP
	} umd_state_t;

	typedef struct packed {
		logic        sel_flash;
		logic        sel_sram;
		logic        sel_idata;
		logic        sel_radio;
		logic        sel_audio;
		logic        sel_sreg;
		logic        sel_usb;
		logic        we;
		logic        cache_fetch;
		logic        flash_fetch;
		logic        dma_grant;
		logic        unmapped;
		logic [15:0] addr;
		logic        wipe_volatile;
		logic        sleep;
	} umd_regs_t;
endpackage
